// ==== src/ptm_pkg.sv ====
package ptm_pkg;
  // Register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0c;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
  localparam logic [7:0] ADDR_PER_LO = 8'h18;
  localparam logic [7:0] ADDR_PER_HI = 8'h1c;
  localparam logic [7:0] ADDR_FLAGS = 8'h20;
  // Control register zero fields
  localparam int CTRL0_HOLD = 7;
  localparam int CTRL0_CLKSEL = 4;
  localparam int CTRL0_RUN = 3;
  // Flag register fields
  localparam int FLAG_A = 0;
  localparam int FLAG_P = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // Timer clock is sys_clk divided by four in select 000
  localparam logic [1:0] DIV4_LAST = 2'h3;

  typedef enum logic [1:0]
  {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } ptm_mode_e;

  typedef struct packed
  {
    ptm_mode_e mode;
    logic [1:0] pin_function;
    logic output_initial_level;
    logic output_invert;
    logic capture_source_select;
    logic clear_source_select;
  } ptm_ctrl1_s;
endpackage : ptm_pkg

// ==== src/ptm_timer.sv ====
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Mode 00 compare, 11 timer, 01 capture; 10 is PWM (pin 00, 01 or 10) or pulse (11).
// - Compare A and period are 16-bit, byte-accessible, read/write, zero after reset.
// - Compare mode, clear select low: clear on P match or overflow; both flags.
// - Compare mode, clear select high: clear on A match; only A flag set.
// - Compare A of zero: counter overflows at FFFF; no A flag.
// - Compare mode: pin changes only on A match per pin function; P ignored.
// - Run rising edge loads the initial level; pin function 00 means no change.
// - Timer mode counts and flags as compare mode but leaves the pin alone.
// - PWM clears on period match; period value, or 65536 for zero; duty is A.
// - PWM duty at or above the period gives 100% output.
// - PWM sets A and P flags on their matches; clear select ignored.
// - PWM: initial level is active level, invert reverses; 00/01 force levels.
// - Pulse mode: run rising edge starts the counter and the pulse.
// - Pulse mode: active external clock edge sets the run bit.
// - Pulse ends on run clear or A match; A match clears run and flags.
// - Pulse mode counter resets only on run rising; period and clear select unused.
// - Capture source is capture pin or external clock pin; edge per pin function.
// - Capture edge latches counter into compare A and flags; counter keeps running.
// - Capture mode: period match zeroes the counter and flags.
// - Capture mode with pin function 11 captures nothing; counter still runs.
// - Capture pulses shorter than two timer clocks may be ignored.
// - Latch within 1.5 timer clocks of the edge; A flag follows the latch.
// - Compare pin function: 00 none, 01 low, 10 high, 11 toggle.
// - Capture pin function: 00 rising, 01 falling, 10 both, 11 disabled.
// - Run rising zeroes the counter; run falling stops it holding its value.
// - Hold bit freezes the counter; clearing it resumes from that value.
module ptm_timer
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_clock_pin,
  input wire logic capture_input_pin,
  output logic timer_out,
  output logic timer_out_drive
);
  ptm_pkg::ptm_ctrl1_s ctrl1_r;
  logic [7:0] ctrl0_r;
  logic [15:0] count_r;
  logic [15:0] compare_a_value_r;
  logic [15:0] period_value_r;
  logic [1:0] flags_r;
  logic [1:0] div_r;
  logic ext_d_r;
  logic cap_d_r;
  logic run_d_r;
  logic pin_r;
  logic out_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  logic run;
  logic hold;
  logic tick;
  logic run_rise;
  logic ext_rise;
  logic ext_fall;
  logic cap_in;
  logic cap_edge;
  logic match_a;
  logic match_p;
  logic clear_cnt;
  logic pulse_mode;
  logic pwm_mode;
  logic pwm_level;
  logic wr_fire;
  logic sw_run_set;
  logic sw_run_clr;
  logic [15:0] count_nxt;

  function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [31:0] d, input logic en);
    byte_merge = en ? d[7:0] : old;
  endfunction : byte_merge

  assign run = ctrl0_r[ptm_pkg::CTRL0_RUN];
  assign hold = ctrl0_r[ptm_pkg::CTRL0_HOLD];
  assign run_rise = run && !run_d_r;
  assign ext_rise = external_clock_pin && !ext_d_r;
  assign ext_fall = !external_clock_pin && ext_d_r;
  assign pwm_mode = ctrl1_r.mode == ptm_pkg::MODE_PWM && ctrl1_r.pin_function != 2'b11;
  assign pulse_mode = ctrl1_r.mode == ptm_pkg::MODE_PWM && ctrl1_r.pin_function == 2'b11;

  // Timer clock source select: 000 div4, 001 sys_clk, 110/111 pin edges; others fall back to sys_clk
  // tick source
  always_comb
  begin
    case (ctrl0_r[ptm_pkg::CTRL0_CLKSEL +: 3])
      3'b000: tick = div_r == ptm_pkg::DIV4_LAST;
      3'b110: tick = ext_rise;
      3'b111: tick = ext_fall;
      default: tick = 1'b1;
    endcase
  end

  assign cap_in = ctrl1_r.capture_source_select ? external_clock_pin : capture_input_pin;
  always_comb
  begin
    logic prev;
    prev = ctrl1_r.capture_source_select ? ext_d_r : cap_d_r;
    case (ctrl1_r.pin_function)
      2'b00: cap_edge = cap_in && !prev;
      2'b01: cap_edge = !cap_in && prev;
      2'b10: cap_edge = cap_in != prev;
      default: cap_edge = 1'b0;
    endcase
  end

  // Matches are seen on the tick that moves the counter onto the value
  // zero compare A never matches
  // A restart zeroes the counter, so the stale count must not match
  assign match_a = tick && run && !hold && !run_rise && compare_a_value_r != ptm_pkg::VALUE_RESET
    && count_r + 16'h0001 == compare_a_value_r;
  assign match_p = tick && run && !hold && !run_rise && period_value_r != ptm_pkg::VALUE_RESET
    && count_r + 16'h0001 == period_value_r;

  always_comb
  begin
    if (pulse_mode)
      clear_cnt = 1'b0;
    else if ((ctrl1_r.mode == ptm_pkg::MODE_COMPARE || ctrl1_r.mode == ptm_pkg::MODE_TIMER)
      && ctrl1_r.clear_source_select)
      clear_cnt = match_a;
    else
      clear_cnt = match_p;
  end

  always_comb
  begin
    count_nxt = count_r;
    if (run_rise)
      count_nxt = ptm_pkg::VALUE_RESET;
    else if (run && !hold && tick)
      count_nxt = clear_cnt ? ptm_pkg::VALUE_RESET : count_r + 16'h0001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      count_r <= ptm_pkg::VALUE_RESET;
    else
      count_r <= count_nxt;
  end

  // no width filter: every sampled edge counts
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      div_r <= 2'h0;
      ext_d_r <= 1'b0;
      cap_d_r <= 1'b0;
      run_d_r <= 1'b0;
    end
    else
    begin
      div_r <= div_r + 2'h1;
      ext_d_r <= external_clock_pin;
      cap_d_r <= capture_input_pin;
      run_d_r <= run;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign wr_fire = aw_got_r && w_got_r;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ptm_pkg::AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_addr_r > ptm_pkg::ADDR_FLAGS || aw_addr_r[1:0] != 2'b00
          ? ptm_pkg::AXI_SLVERR : ptm_pkg::AXI_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign sw_run_set = wr_fire && aw_addr_r == ptm_pkg::ADDR_CTRL0 && w_strb_r[0] && w_data_r[ptm_pkg::CTRL0_RUN];
  assign sw_run_clr = wr_fire && aw_addr_r == ptm_pkg::ADDR_CTRL0 && w_strb_r[0] && !w_data_r[ptm_pkg::CTRL0_RUN];

  // Control registers; hardware run set and clear in pulse mode
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl0_r <= ptm_pkg::CTRL_RESET;
      ctrl1_r <= ptm_pkg::ptm_ctrl1_s'(ptm_pkg::CTRL_RESET);
    end
    else
    begin
      if (wr_fire && aw_addr_r == ptm_pkg::ADDR_CTRL0 && w_strb_r[0])
        ctrl0_r[7:3] <= w_data_r[7:3];
      if (wr_fire && aw_addr_r == ptm_pkg::ADDR_CTRL1)
        ctrl1_r <= ptm_pkg::ptm_ctrl1_s'(byte_merge(ctrl1_r, w_data_r, w_strb_r[0]));
      if (pulse_mode && !run && !sw_run_clr
        && (ctrl0_r[ptm_pkg::CTRL0_CLKSEL +: 3] == 3'b111 ? ext_fall : ext_rise))
        ctrl0_r[ptm_pkg::CTRL0_RUN] <= 1'b1;
      // A match ends the pulse and clears run
      if (pulse_mode && match_a && !sw_run_set)
        ctrl0_r[ptm_pkg::CTRL0_RUN] <= 1'b0;
    end
  end

  // compare A written by software or latched by capture
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      compare_a_value_r <= ptm_pkg::VALUE_RESET;
      period_value_r <= ptm_pkg::VALUE_RESET;
    end
    else
    begin
      if (wr_fire && aw_addr_r == ptm_pkg::ADDR_CMPA_LO)
        compare_a_value_r[7:0] <= byte_merge(compare_a_value_r[7:0], w_data_r, w_strb_r[0]);
      if (wr_fire && aw_addr_r == ptm_pkg::ADDR_CMPA_HI)
        compare_a_value_r[15:8] <= byte_merge(compare_a_value_r[15:8], w_data_r, w_strb_r[0]);
      if (wr_fire && aw_addr_r == ptm_pkg::ADDR_PER_LO)
        period_value_r[7:0] <= byte_merge(period_value_r[7:0], w_data_r, w_strb_r[0]);
      if (wr_fire && aw_addr_r == ptm_pkg::ADDR_PER_HI)
        period_value_r[15:8] <= byte_merge(period_value_r[15:8], w_data_r, w_strb_r[0]);
      // disabled edge select never fires; capture beats a same-cycle write
      if (ctrl1_r.mode == ptm_pkg::MODE_CAPTURE && run && cap_edge)
        compare_a_value_r <= count_r;
    end
  end

  // Flags: hardware set wins over a write-one-to-clear in the same cycle
  // flag sources
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      flags_r <= 2'b00;
    else
    begin
      if (wr_fire && aw_addr_r == ptm_pkg::ADDR_FLAGS && w_strb_r[0])
        flags_r <= flags_r & ~w_data_r[1:0];
      if (match_a && ctrl1_r.mode != ptm_pkg::MODE_CAPTURE)
        flags_r[ptm_pkg::FLAG_A] <= 1'b1;
      // capture raises A flag in the same cycle as the latch
      if (ctrl1_r.mode == ptm_pkg::MODE_CAPTURE && run && cap_edge)
        flags_r[ptm_pkg::FLAG_A] <= 1'b1;
      if (match_p && !pulse_mode && !((ctrl1_r.mode == ptm_pkg::MODE_COMPARE
        || ctrl1_r.mode == ptm_pkg::MODE_TIMER) && ctrl1_r.clear_source_select))
        flags_r[ptm_pkg::FLAG_P] <= 1'b1;
    end
  end

  // PWM active while count below duty; duty at or above period holds active
  assign pwm_level = count_r < compare_a_value_r || (period_value_r != ptm_pkg::VALUE_RESET
    && compare_a_value_r >= period_value_r);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pin_r <= 1'b0;
    else if (run_rise)
      pin_r <= ctrl1_r.output_initial_level;
    // Pulse is active at the initial level; idle is its inverse
    else if (pulse_mode && (match_a || !run))
      pin_r <= ~ctrl1_r.output_initial_level;
    else if (ctrl1_r.mode == ptm_pkg::MODE_COMPARE && match_a)
      case (ctrl1_r.pin_function)
        2'b01: pin_r <= 1'b0;
        2'b10: pin_r <= 1'b1;
        2'b11: pin_r <= ~pin_r;
        default: pin_r <= pin_r;
      endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      out_r <= 1'b0;
    else if (pwm_mode)
      case (ctrl1_r.pin_function)
        2'b00: out_r <= ~ctrl1_r.output_initial_level ^ ctrl1_r.output_invert;
        2'b01: out_r <= ctrl1_r.output_initial_level ^ ctrl1_r.output_invert;
        default: out_r <= (pwm_level ? ctrl1_r.output_initial_level : ~ctrl1_r.output_initial_level)
          ^ ctrl1_r.output_invert;
      endcase
    else
      out_r <= pin_r ^ ctrl1_r.output_invert;
  end

  // pin released in timer and capture modes
  assign timer_out = out_r;
  assign timer_out_drive = ctrl1_r.mode == ptm_pkg::MODE_COMPARE || ctrl1_r.mode == ptm_pkg::MODE_PWM;

  // Read path answers one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ptm_pkg::AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ptm_pkg::AXI_OKAY;
      case (s_axi_araddr)
        ptm_pkg::ADDR_CTRL0: s_axi_rdata <= {24'h0, ctrl0_r[7:3], 3'b000};
        ptm_pkg::ADDR_CTRL1: s_axi_rdata <= {24'h0, ctrl1_r};
        ptm_pkg::ADDR_CNT_LO: s_axi_rdata <= {24'h0, count_r[7:0]};
        ptm_pkg::ADDR_CNT_HI: s_axi_rdata <= {24'h0, count_r[15:8]};
        ptm_pkg::ADDR_CMPA_LO: s_axi_rdata <= {24'h0, compare_a_value_r[7:0]};
        ptm_pkg::ADDR_CMPA_HI: s_axi_rdata <= {24'h0, compare_a_value_r[15:8]};
        ptm_pkg::ADDR_PER_LO: s_axi_rdata <= {24'h0, period_value_r[7:0]};
        ptm_pkg::ADDR_PER_HI: s_axi_rdata <= {24'h0, period_value_r[15:8]};
        ptm_pkg::ADDR_FLAGS: s_axi_rdata <= {30'h0, flags_r};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ptm_pkg::AXI_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  reset_clear_a: assert property (@(posedge sys_clk) $past(reset) |-> period_value_r == 16'h0000)
    else $error("period not cleared by reset");
  // zero compare gives no A match
  zero_cmpa_a: assert property (@(posedge sys_clk) disable iff (reset)
    compare_a_value_r == 16'h0000 && ctrl1_r.mode != ptm_pkg::MODE_CAPTURE && !flags_r[0] && !wr_fire
    |=> !flags_r[0])
    else $error("match A flag with zero compare");
  run_rise_a: assert property (@(posedge sys_clk) disable iff (reset) run_rise |=> count_r == 16'h0000)
    else $error("counter not zeroed on run rise");
  hold_freeze_a: assert property (@(posedge sys_clk) disable iff (reset)
    run && hold && !run_rise |=> $stable(count_r))
    else $error("counter moved while held");
  // no P flag with A clear
  no_pflag_a: assert property (@(posedge sys_clk) disable iff (reset)
    ctrl1_r.mode == ptm_pkg::MODE_COMPARE && ctrl1_r.clear_source_select && !flags_r[1] && !wr_fire
    |=> !flags_r[1])
    else $error("P flag set with A clear select");
  pulse_end_a: assert property (@(posedge sys_clk) disable iff (reset)
    pulse_mode && match_a && !wr_fire |=> !run ##1 out_r == (~ctrl1_r.output_initial_level ^ ctrl1_r.output_invert))
    else $error("pulse did not end on match A");
  cap_latch_a: assert property (@(posedge sys_clk) disable iff (reset)
    ctrl1_r.mode == ptm_pkg::MODE_CAPTURE && run && cap_edge |=> compare_a_value_r == $past(count_r) && flags_r[0])
    else $error("capture latch failed");
  count_inc_a: assert property (@(posedge sys_clk) disable iff (reset)
    run && !hold && tick && !clear_cnt && !run_rise |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter failed to increment");
  cap_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    ctrl1_r.mode == ptm_pkg::MODE_CAPTURE && ctrl1_r.pin_function == 2'b11 && !wr_fire |=> $stable(compare_a_value_r))
    else $error("capture while disabled");

  cap_seen_c: cover property (@(posedge sys_clk) ctrl1_r.mode == ptm_pkg::MODE_CAPTURE && cap_edge && run);
  pulse_seen_c: cover property (@(posedge sys_clk) pulse_mode && match_a);
  pwm_seen_c: cover property (@(posedge sys_clk) pwm_mode && match_p);
endmodule : ptm_timer

// ==== tb/ptm_pin_model.sv ====
`timescale 1ns/1ps
module ptm_pin_model
(
  input wire logic sys_clk,
  input wire logic timer_out,
  input wire logic timer_out_drive,
  output logic external_clock_pin,
  output logic capture_input_pin,
  output logic pin_level
);
  // Pull-down load, so a released pin reads low and never the last driven level
  assign pin_level = timer_out_drive ? timer_out : 1'b0;

  initial
  begin
    external_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
  end

  // wide input levels
  // Each level stands four timer clocks, well above the width that may be dropped
  task automatic set_pin(input logic sel, input logic lvl);
    @(posedge sys_clk);
    if (sel)
      external_clock_pin <= lvl;
    else
      capture_input_pin <= lvl;
    repeat (4) @(posedge sys_clk);
  endtask : set_pin
endmodule : ptm_pin_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rv, c, h;
  logic external_clock_pin, capture_input_pin, timer_out, timer_out_drive, pin_level, init, inv;
  logic [7:0] a;
  logic [7:0] regs [4] = '{ptm_pkg::ADDR_CMPA_LO, ptm_pkg::ADDR_CMPA_HI, ptm_pkg::ADDR_PER_LO, ptm_pkg::ADDR_PER_HI};
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int highs;

  always #2 sys_clk = ~sys_clk;

  ptm_timer dut_u
  (
    .sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .external_clock_pin(external_clock_pin), .capture_input_pin(capture_input_pin),
    .timer_out(timer_out), .timer_out_drive(timer_out_drive)
  );

  ptm_pin_model partner_u
  (
    .sys_clk(sys_clk), .timer_out(timer_out), .timer_out_drive(timer_out_drive),
    .external_clock_pin(external_clock_pin), .capture_input_pin(capture_input_pin), .pin_level(pin_level)
  );

  task automatic close_out();
    $display("Checks made %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  // Whole run needs well under ten thousand cycles
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] ad);
    @(posedge sys_clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  // Only meaningful while the counter is stopped or held
  task automatic rd_cnt(output logic [31:0] cv);
    axr(ptm_pkg::ADDR_CNT_HI);
    cv = rv << 8;
    axr(ptm_pkg::ADDR_CNT_LO);
    cv = cv | rv;
  endtask : rd_cnt

  task automatic setup(input logic [7:0] c1, input logic [15:0] ca, input logic [15:0] cp);
    axw(ptm_pkg::ADDR_CTRL0, 8'h10);
    axw(ptm_pkg::ADDR_CTRL1, c1);
    axw(ptm_pkg::ADDR_CMPA_LO, ca[7:0]);
    axw(ptm_pkg::ADDR_CMPA_HI, ca[15:8]);
    axw(ptm_pkg::ADDR_PER_LO, cp[7:0]);
    axw(ptm_pkg::ADDR_PER_HI, cp[15:8]);
    axw(ptm_pkg::ADDR_FLAGS, 8'h03);
  endtask : setup

  task automatic run_for(input int n);
    axw(ptm_pkg::ADDR_CTRL0, 8'h18);
    repeat (n) @(posedge sys_clk);
  endtask : run_for

  function automatic logic cmp_pin(input logic [1:0] pf, input logic lv);
    case (pf)
      2'b00: return lv;
      2'b01: return 1'b0;
      2'b10: return 1'b1;
      default: return ~lv;
    endcase
  endfunction : cmp_pin

  // High cycles per period; lv is the pin level during the active part
  function automatic int pwm_highs(input int ad, input int pd, input logic [1:0] pf, input logic lv);
    int act;
    act = (pf == 2'b00) ? 0 : (pf == 2'b01 || ad >= pd) ? pd : ad;
    return lv ? act : pd - act;
  endfunction : pwm_highs

  initial
  begin
    void'($urandom(32'h6b7d11de));
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (regs[i])
    begin
      axr(regs[i]);
      chk(rv, 32'h0);
      a = 8'($urandom_range(255, 0));
      axw(regs[i], a);
      axr(regs[i]);
      chk(rv, {24'h0, a});
    end
    axr(8'h24);
    chk(resp, ptm_pkg::AXI_SLVERR);
    axw(8'h24, 8'h5a);
    chk(resp, ptm_pkg::AXI_SLVERR);
    for (int i = 0; i < 8; i++)
    begin
      init = i[0];
      setup({2'b00, i[2:1], init, 3'b000}, 16'($urandom_range(40, 20)), 16'h0000);
      run_for(60);
      chk(timer_out, cmp_pin(i[2:1], init));
      axr(ptm_pkg::ADDR_FLAGS);
      chk(rv, 32'h1);
      axw(ptm_pkg::ADDR_CTRL0, 8'h10);
      run_for(2);
      chk(timer_out, init);
    end
    setup(8'h20, 16'd5, 16'd10);
    run_for(40);
    chk(timer_out_drive, 1'b1);
    axw(ptm_pkg::ADDR_CTRL0, 8'h10);
    axr(ptm_pkg::ADDR_FLAGS);
    chk(rv, 32'h3);
    rd_cnt(c);
    chk(c < 10, 1'b1);
    setup(8'h31, 16'd6, 16'd3);
    run_for(40);
    axw(ptm_pkg::ADDR_CTRL0, 8'h10);
    axr(ptm_pkg::ADDR_FLAGS);
    chk(rv, 32'h1);
    rd_cnt(c);
    chk(c < 6, 1'b1);
    setup(8'h20, 16'h0000, 16'h0000);
    run_for(40);
    axr(ptm_pkg::ADDR_FLAGS);
    chk(rv, 32'h0);
    chk(timer_out, 1'b0);
    axw(ptm_pkg::ADDR_CTRL0, 8'h98);
    rd_cnt(h);
    rd_cnt(c);
    chk(c, h);
    axw(ptm_pkg::ADDR_CTRL0, 8'h18);
    axw(ptm_pkg::ADDR_CTRL0, 8'h10);
    rd_cnt(c);
    chk(c > h, 1'b1);
    rd_cnt(h);
    chk(h, c);
    run_for(2);
    axw(ptm_pkg::ADDR_CTRL0, 8'h10);
    rd_cnt(c);
    chk(c < 20, 1'b1);
    setup(8'hc0, 16'd5, 16'd10);
    run_for(40);
    chk(timer_out_drive, 1'b0);
    chk(pin_level, 1'b0);
    axr(ptm_pkg::ADDR_FLAGS);
    chk(rv, 32'h3);
    for (int i = 0; i < 8; i++)
    begin
      init = 1'($urandom_range(1, 0));
      inv = 1'($urandom_range(1, 0));
      // Duty equal to and above the period in two full PWM runs
      a = (i == 2 || i == 5) ? 8'(6 + i) : 8'($urandom_range(7, 1));
      setup({2'b10, 2'(i % 3), init, inv, 2'b11}, {8'h00, a}, 16'd8);
      run_for(20);
      highs = 0;
      repeat (80) @(posedge sys_clk) highs += (timer_out === 1'b1);
      chk(highs, 10 * pwm_highs(a, 8, 2'(i % 3), init ^ inv));
      axr(ptm_pkg::ADDR_FLAGS);
      chk(rv, {30'h0, 1'b1, a < 9});
    end
    setup(8'hb8, 16'd30, 16'h0000);
    run_for(2);
    chk(timer_out, 1'b1);
    repeat (40) @(posedge sys_clk);
    chk(timer_out, 1'b0);
    axr(ptm_pkg::ADDR_CTRL0);
    chk(rv[3], 1'b0);
    axr(ptm_pkg::ADDR_FLAGS);
    chk(rv[0], 1'b1);
    axw(ptm_pkg::ADDR_CMPA_LO, 8'hc8);
    partner_u.set_pin(1'b1, 1'b1);
    chk(timer_out, 1'b1);
    axr(ptm_pkg::ADDR_CTRL0);
    chk(rv[3], 1'b1);
    axw(ptm_pkg::ADDR_CTRL0, 8'h10);
    run_for(0);
    axw(ptm_pkg::ADDR_CTRL0, 8'h10);
    // Pin and output register each take one edge after the run bit drops
    repeat (2) @(posedge sys_clk);
    chk(timer_out, 1'b0);
    partner_u.set_pin(1'b1, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      setup({2'b01, i[1:0], 2'b00, i[2], 1'b0}, 16'h0000, 16'h0000);
      run_for(20);
      partner_u.set_pin(i[2], 1'b1);
      axr(ptm_pkg::ADDR_FLAGS);
      chk(rv[0], !i[0]);
      axr(ptm_pkg::ADDR_CMPA_LO);
      chk(rv != 0, !i[0]);
      axw(ptm_pkg::ADDR_FLAGS, 8'h03);
      partner_u.set_pin(i[2], 1'b0);
      axr(ptm_pkg::ADDR_FLAGS);
      chk(rv[0], i[0] ^ i[1]);
    end
    setup(8'h70, 16'h0000, 16'd12);
    run_for(60);
    axw(ptm_pkg::ADDR_CTRL0, 8'h10);
    axr(ptm_pkg::ADDR_FLAGS);
    chk(rv[1], 1'b1);
    rd_cnt(c);
    chk(c < 12, 1'b1);
    close_out();
  end
endmodule : testbench
